// ===== shared/swtr_defs.svh
// register offsets, field positions and reset values
// assumes a 16-bit plain register port
`ifndef SWTR_DEFS_SVH
`define SWTR_DEFS_SVH
`define SWTR_OFF_WAKE_SEL 16'h0040
`define SWTR_OFF_SEQ_SEL  16'h0041
`define SWTR_OFF_REG_EN   16'h0042
`define SWTR_OFF_STATE    16'h0043
`define SWTR_OFF_TRIG     16'h0d50
`define SWTR_OFF_IRQ_STS  16'h0d51
`define SWTR_OFF_IRQ_CLR  16'h0d52
`define SWTR_OFF_IRQ_EN   16'h0d53
`define SWTR_EDGE_HI      7
`define SWTR_EDGE_LO      2
`define SWTR_REG_EN_BIT   0
`define SWTR_SEL_RST      6'h00
`define SWTR_REG_EN_RST   1'b1
`define SWTR_SLEEP_IRQ    6'h0f
`define SWTR_ALL_EDGES    6'h3f
`endif

// ===== shared/swtr_pkg.sv
// types for the sleep wake trigger router
// assumes swtr_defs.svh for all numbers
package swtr_pkg;
  typedef enum logic [1:0] {
    SWTR_SLEEP  = 2'b00,
    SWTR_WAKING = 2'b01,
    SWTR_NORMAL = 2'b10
  } swtr_state_e;

  typedef struct packed {
    logic mic_clamp_status;
    logic pin_five_signal;
    logic jack_detect_signal;
  } swtr_sig_s;

  // [5] clamp fall .. [0] jack rise
  typedef logic [5:0] swtr_edge_t;
endpackage

// ===== verilog/swtr_top.sv
// sleep wake trigger router: edge latches, wake, sequencer, irq
// assumes debounced inputs synchronous to mclk_in
//
// What this block does
// - six wake select bits, 7 downto 2
// - selected latched edge wakes core regulator
// - status stays latched; clearing drops wake request
// - six sequencer select bits, same layout
// - sequencer starts only in normal operation
// - selected edge schedules its control sequence
// - writing zero enable sleeps, pin and wake request deasserted
// - separate irq mask per edge
// - pin five works as input during sleep
// - every edge sets status; write one clears
// - regulator pin high wakes regardless of selects
// - sleep irq only jack/pin five, held
`timescale 1ns/1ps
`include "swtr_defs.svh"

module swtr_top
  import swtr_pkg::*;
(
  input  logic        mclk_in,                // 25 MHz clock
  input  logic        arst_n_in,              // async reset
  input  swtr_sig_s   sig_in,                 // debounced levels
  input  logic        regulator_enable_pin_in,// regulator pin
  input  logic [15:0] addr_in,                // register address
  input  logic [15:0] wdata_in,               // write data
  input  logic        wr_in,                  // write strobe
  input  logic        rd_in,                  // read strobe
  output logic [15:0] rdata_out,              // read data
  output logic        core_reg_on_out,        // core regulator on
  output logic        core_supply_on_out,     // core supply on
  output logic        normal_out,             // normal operation
  output logic        seq_start_out,          // sequence pulse
  output logic [5:0]  seq_src_out,            // starting edges
  output logic        irq_out                 // interrupt, high
);

  swtr_sig_s   prev;
  logic        primed;
  swtr_edge_t  edge_now;
  swtr_edge_t  wake_sel;
  swtr_edge_t  seq_sel;
  logic        core_regulator_enable;
  swtr_edge_t  edge_trigger_status;
  swtr_edge_t  irq_sts;
  swtr_edge_t  irq_en;
  swtr_state_e state;
  swtr_state_e next_state;
  logic        irq_hold;
  logic        wake_req;
  logic        next_core_on;
  logic        asleep;
  logic        irq_live;
  swtr_edge_t  trig_clr;
  swtr_edge_t  irq_clr;
  swtr_edge_t  seq_hit;
  logic [15:0] rd_mux;
  logic        wr_wake;
  logic        wr_seq;
  logic        wr_regen;
  logic        wr_trig;
  logic        wr_iclr;
  logic        wr_ien;

  // register write decode
  assign wr_wake  = wr_in && (addr_in == `SWTR_OFF_WAKE_SEL);
  assign wr_seq   = wr_in && (addr_in == `SWTR_OFF_SEQ_SEL);
  assign wr_regen = wr_in && (addr_in == `SWTR_OFF_REG_EN);
  assign wr_trig  = wr_in && (addr_in == `SWTR_OFF_TRIG);
  assign wr_iclr  = wr_in && (addr_in == `SWTR_OFF_IRQ_CLR);
  assign wr_ien   = wr_in && (addr_in == `SWTR_OFF_IRQ_EN);

  assign trig_clr = wr_trig ?
    wdata_in[`SWTR_EDGE_HI:`SWTR_EDGE_LO] : 6'h00;
  assign irq_clr  = wr_iclr ?
    wdata_in[`SWTR_EDGE_HI:`SWTR_EDGE_LO] : 6'h00;

  // edge detection, live in every state
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prev   <= '0;
      primed <= 1'b0;
    end else begin
      prev   <= sig_in;
      primed <= 1'b1;
    end
  end

  always_comb begin
    edge_now    = 6'h00;
    edge_now[0] = sig_in.jack_detect_signal
                  & ~prev.jack_detect_signal;
    edge_now[1] = ~sig_in.jack_detect_signal
                  & prev.jack_detect_signal;
    edge_now[2] = sig_in.pin_five_signal
                  & ~prev.pin_five_signal;
    edge_now[3] = ~sig_in.pin_five_signal
                  & prev.pin_five_signal;
    edge_now[4] = sig_in.mic_clamp_status
                  & ~prev.mic_clamp_status;
    edge_now[5] = ~sig_in.mic_clamp_status
                  & prev.mic_clamp_status;
    if (!primed) begin
      edge_now = 6'h00;
    end
  end

  // select registers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wake_sel <= `SWTR_SEL_RST;
      seq_sel  <= `SWTR_SEL_RST;
    end else begin
      if (wr_wake) begin
        wake_sel <= wdata_in[`SWTR_EDGE_HI:`SWTR_EDGE_LO];
      end
      if (wr_seq) begin
        seq_sel <= wdata_in[`SWTR_EDGE_HI:`SWTR_EDGE_LO];
      end
    end
  end

  // core regulator enable, written only through its register
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_regulator_enable <= `SWTR_REG_EN_RST;
    end else if (wr_regen) begin
      core_regulator_enable <= wdata_in[`SWTR_REG_EN_BIT];
    end
  end

  // latched trigger status, set wins over clear
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      edge_trigger_status <= 6'h00;
    end else begin
      edge_trigger_status <= (edge_trigger_status & ~trig_clr)
                             | edge_now;
    end
  end

  // wake request and regulator control
  assign wake_req = |(edge_trigger_status & wake_sel);
  assign next_core_on = wake_req
                        | core_regulator_enable
                        | regulator_enable_pin_in;

  always_comb begin
    case (state)
      SWTR_SLEEP: begin
        next_state = next_core_on ? SWTR_WAKING : SWTR_SLEEP;
      end
      SWTR_WAKING: begin
        next_state = next_core_on ? SWTR_NORMAL : SWTR_SLEEP;
      end
      SWTR_NORMAL: begin
        next_state = next_core_on ? SWTR_NORMAL : SWTR_SLEEP;
      end
      default: begin
        next_state = SWTR_SLEEP;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state              <= SWTR_SLEEP;
      core_reg_on_out    <= 1'b0;
      core_supply_on_out <= 1'b0;
      normal_out         <= 1'b0;
    end else begin
      state              <= next_state;
      core_reg_on_out    <= next_core_on;
      core_supply_on_out <= next_core_on;
      normal_out         <= (next_state == SWTR_NORMAL);
    end
  end

  // sequencer: fresh edges only, and only when running
  assign seq_hit = (state == SWTR_NORMAL) ?
                   (edge_now & seq_sel) : 6'h00;

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      seq_start_out <= 1'b0;
      seq_src_out   <= 6'h00;
    end else begin
      seq_start_out <= |seq_hit;
      seq_src_out   <= seq_hit;
    end
  end

  // interrupt status, enable and clear
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_sts <= 6'h00;
      irq_en  <= 6'h00;
    end else begin
      irq_sts <= (irq_sts & ~irq_clr) | edge_now;
      if (wr_ien) begin
        irq_en <= wdata_in[`SWTR_EDGE_HI:`SWTR_EDGE_LO];
      end
    end
  end

  assign asleep   = (state != SWTR_NORMAL);
  assign irq_live = |(irq_sts & irq_en & (asleep ?
                    `SWTR_SLEEP_IRQ : `SWTR_ALL_EDGES));

  // an irq raised asleep stays until the wake completes
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_hold <= 1'b0;
    end else if (state == SWTR_WAKING && next_core_on) begin
      irq_hold <= 1'b0;
    end else if (state == SWTR_SLEEP && irq_live) begin
      irq_hold <= 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= irq_live | irq_hold;
    end
  end

  // read path
  always_comb begin
    rd_mux = 16'h0000;
    case (addr_in)
      `SWTR_OFF_WAKE_SEL: begin
        rd_mux[`SWTR_EDGE_HI:`SWTR_EDGE_LO] = wake_sel;
      end
      `SWTR_OFF_SEQ_SEL: begin
        rd_mux[`SWTR_EDGE_HI:`SWTR_EDGE_LO] = seq_sel;
      end
      `SWTR_OFF_REG_EN: begin
        rd_mux[`SWTR_REG_EN_BIT] = core_regulator_enable;
      end
      `SWTR_OFF_STATE: begin
        rd_mux[3:0] = {state, core_reg_on_out, wake_req};
      end
      `SWTR_OFF_TRIG: begin
        rd_mux[`SWTR_EDGE_HI:`SWTR_EDGE_LO] = edge_trigger_status;
      end
      `SWTR_OFF_IRQ_STS: begin
        rd_mux[`SWTR_EDGE_HI:`SWTR_EDGE_LO] = irq_sts;
      end
      `SWTR_OFF_IRQ_EN: begin
        rd_mux[`SWTR_EDGE_HI:`SWTR_EDGE_LO] = irq_en;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_out <= 16'h0000;
    end else begin
      rdata_out <= rd_in ? rd_mux : 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!arst_n_in);

  wake_sel_rd_a: assert property (
    wr_wake ##1 (rd_in && addr_in == `SWTR_OFF_WAKE_SEL && !wr_in)
    |=> rdata_out[7:2] == $past(wdata_in[7:2], 2)
        && rdata_out[1:0] == 2'b00)
    else $error("wake select readback wrong");

  wake_on_req_a: assert property (
    (state == SWTR_SLEEP && wake_req)
    |=> core_reg_on_out && state == SWTR_WAKING ##1
        state == SWTR_NORMAL || !core_reg_on_out)
    else $error("selected status did not wake");

  trig_latch_a: assert property (
    1'b1 |=> (edge_trigger_status
              & $past(edge_trigger_status & ~trig_clr))
             == $past(edge_trigger_status & ~trig_clr))
    else $error("trigger status lost without clear");

  regoff_sleep_a: assert property (
    (!core_regulator_enable && !regulator_enable_pin_in
     && !wake_req) |=> !core_reg_on_out && !core_supply_on_out)
    else $error("regulator stayed on without cause");

  edge_set_a: assert property (
    (edge_now != 6'h00)
    |=> (edge_trigger_status & $past(edge_now)) == $past(edge_now)
        && (irq_sts & $past(edge_now)) == $past(edge_now))
    else $error("edge did not set status");

  seq_sched_a: assert property (
    (state == SWTR_NORMAL && (edge_now & seq_sel) != 6'h00)
    |=> seq_start_out && seq_src_out == $past(edge_now & seq_sel))
    else $error("sequence not scheduled");

  seq_normal_a: assert property (
    seq_start_out |-> $past(state) == SWTR_NORMAL)
    else $error("sequence started outside normal");

  pin_wake_a: assert property (
    regulator_enable_pin_in |=> core_reg_on_out
    && state != SWTR_SLEEP)
    else $error("regulator pin did not wake");

  sleep_irq_a: assert property (
    (state == SWTR_SLEEP && !irq_hold
     && (irq_sts & irq_en & `SWTR_SLEEP_IRQ) == 6'h00)
    |=> !irq_out)
    else $error("irq in sleep from clamp edge");

  irq_hold_a: assert property (
    (state == SWTR_SLEEP && irq_live) ##1 (state == SWTR_SLEEP)
    |=> irq_out)
    else $error("sleep irq dropped before wake");

  req_or_a: assert property (
    (wake_req || core_regulator_enable) |=> core_reg_on_out)
    else $error("regulator off while requested");

  pf_wake_c: cover property (
    state == SWTR_SLEEP && edge_now[2] && wake_sel[2]
    ##2 state == SWTR_NORMAL);
  seq_run_c: cover property (seq_start_out);
  sleep_irq_c: cover property (state == SWTR_SLEEP && irq_out);
  seq_sleep_c: cover property (
    state == SWTR_NORMAL ##1 state == SWTR_SLEEP);

endmodule // swtr_top

// ===== sim/swtr_host_model.sv
// detection inputs seen by the router: jack, pin five, clamp levels
// assumes bench pulses toggle_in for one cycle per wanted edge
`timescale 1ns/1ps

module swtr_host_model
  import swtr_pkg::*;
(
  input  wire logic       mclk_in,   // 25 MHz clock
  input  wire logic       arst_n_in, // async reset
  input  wire logic [2:0] toggle_in, // flip these levels
  output swtr_sig_s       sig_out    // levels to the router
);
  // levels flip in sleep as well as in normal operation
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sig_out <= '0;
    end else begin
      sig_out <= sig_out ^ swtr_sig_s'(toggle_in);
    end
  end
endmodule // swtr_host_model

// ===== sim/tb_top.sv
// self-checking bench for the sleep wake trigger router
// assumes the host model drives the detection levels
`timescale 1ns/1ps
`include "swtr_defs.svh"

module tb_top
  import swtr_pkg::*;
;
  logic        mclk_in = 0, arst_n_in = 0, pin = 0, wr = 0, rd = 0;
  logic [15:0] addr = 0, wdata = 0, rdata, v;
  logic [2:0]  tog = 0;
  logic        clr_seen = 0;
  logic [5:0]  seq_src, seen = 0;
  logic        core_on, supply_on, normal, seq_start, irq;
  swtr_sig_s   sig;
  int          n_fail = 0, checked = 0, k;

  swtr_host_model u_swtr_host_model (.mclk_in(mclk_in),
    .arst_n_in(arst_n_in), .toggle_in(tog), .sig_out(sig));
  swtr_top u_swtr_top (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
    .sig_in(sig), .regulator_enable_pin_in(pin), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .core_reg_on_out(core_on), .core_supply_on_out(supply_on),
    .normal_out(normal), .seq_start_out(seq_start),
    .seq_src_out(seq_src), .irq_out(irq));

  initial begin
    forever #20 mclk_in = ~mclk_in;
  end

  // gather every sequence pulse
  always @(posedge mclk_in) begin
    if (clr_seen) begin
      seen <= 6'h00;
    end else if (seq_start === 1'b1) begin
      seen <= seen | seq_src;
    end
  end

  task automatic stop_test();
    if (n_fail == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in);
    wr    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in);
    rd   <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // one edge on the chosen levels, then let it settle
  task automatic toggle(input logic [2:0] t);
    @(posedge mclk_in);
    tog <= t;
    @(posedge mclk_in);
    tog <= 3'h0;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask

  task automatic clear_seen();
    @(posedge mclk_in);
    clr_seen <= 1'b1;
    @(posedge mclk_in);
    clr_seen <= 1'b0;
  endtask

  // edge register view of a written word: bits 7..2 only
  function automatic logic [15:0] sel_view(input logic [15:0] d);
    return d & 16'h00fc;
  endfunction

  task automatic wait_normal();
    for (int i = 0; i < 20 && normal !== 1'b1; i++) begin
      @(posedge mclk_in);
      #1;
    end
    if (normal !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(56121));
    repeat (20) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    wait_normal();
    rd_chk(`SWTR_OFF_WAKE_SEL, 16'h0000);
    rd_chk(`SWTR_OFF_SEQ_SEL, 16'h0000);
    rd_chk(`SWTR_OFF_REG_EN, 16'h0001);
    rd_chk(`SWTR_OFF_STATE, 16'h000a);
    rd_chk(16'h0100, 16'h0000);
    for (k = 0; k < 8; k++) begin
      v = 16'($urandom);
      wr_reg(`SWTR_OFF_WAKE_SEL, v);
      wr_reg(`SWTR_OFF_SEQ_SEL, ~v);
      rd_chk(`SWTR_OFF_WAKE_SEL, sel_view(v));
      rd_chk(`SWTR_OFF_SEQ_SEL, sel_view(~v));
    end
    // every edge in normal operation starts its own sequence
    wr_reg(`SWTR_OFF_SEQ_SEL, 16'h00fc);
    wr_reg(`SWTR_OFF_WAKE_SEL, 16'h0004);
    for (k = 0; k < 6; k++) begin
      clear_seen();
      toggle(3'h1 << (k / 2));
      chk(16'(seen), 16'h0001 << k);
      rd_chk(`SWTR_OFF_TRIG, 16'h0004 << k);
      wr_reg(`SWTR_OFF_TRIG, 16'h0004 << k);
      rd_chk(`SWTR_OFF_TRIG, 16'h0000);
    end
    // sleep, clamp edge neither wakes nor interrupts
    wr_reg(`SWTR_OFF_IRQ_CLR, 16'h00fc);
    wr_reg(`SWTR_OFF_IRQ_EN, 16'h00fc);
    wr_reg(`SWTR_OFF_REG_EN, 16'h0000);
    repeat (2) @(posedge mclk_in);
    #1;
    chk(16'({core_on, normal}), 16'h0000);
    clear_seen();
    toggle(3'h4);
    chk(16'({core_on, irq}), 16'h0000);
    // jack rise wakes, no sequence from the waking edge
    toggle(3'h1);
    chk(16'(irq), 16'h0001);
    wait_normal();
    chk(16'({core_on, supply_on}), 16'h0003);
    chk(16'(seen), 16'h0000);
    // keep the regulator on before clearing status
    wr_reg(`SWTR_OFF_REG_EN, 16'h0001);
    wr_reg(`SWTR_OFF_TRIG, 16'h00fc);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(16'(core_on), 16'h0001);
    // per-edge interrupt masks
    wr_reg(`SWTR_OFF_IRQ_EN, 16'h0010);
    wr_reg(`SWTR_OFF_IRQ_CLR, 16'h00fc);
    toggle(3'h1);
    chk(16'(irq), 16'h0000);
    toggle(3'h2);
    chk(16'(irq), 16'h0001);
    rd_chk(`SWTR_OFF_IRQ_STS, 16'h0018);
    rd_chk(`SWTR_OFF_IRQ_EN, 16'h0010);
    // clearing the wake status without enable drops the regulator
    wr_reg(`SWTR_OFF_TRIG, 16'h00fc);
    wr_reg(`SWTR_OFF_REG_EN, 16'h0000);
    toggle(3'h1);
    wait_normal();
    chk(16'(core_on), 16'h0001);
    wr_reg(`SWTR_OFF_TRIG, 16'h0004);
    repeat (3) @(posedge mclk_in);
    #1;
    chk(16'({core_on, normal}), 16'h0000);
    // regulator pin wakes with no selected edge latched
    @(posedge mclk_in);
    pin <= 1'b1;
    wait_normal();
    chk(16'(core_on), 16'h0001);
    @(posedge mclk_in);
    pin <= 1'b0;
    repeat (3) @(posedge mclk_in);
    #1;
    chk(16'(core_on), 16'h0000);
    stop_test();
  end
endmodule // tb_top
